// ### logic/tam_regs.svh
// Register offsets, field positions, reset values and timing counts for the T1 alarm threshold monitor.
// Assumes a plain register port with one-cycle strobes and 32-bit data.
`ifndef TAM_REGS_SVH
`define TAM_REGS_SVH
`define TAM_OFF_CTRL      8'h00
`define TAM_OFF_L1CFG     8'h04
`define TAM_OFF_L2CFG     8'h08
`define TAM_OFF_SLIPCFG   8'h0C
`define TAM_OFF_TIME      8'h10
`define TAM_OFF_DATE      8'h14
`define TAM_OFF_STATUS    8'h18
`define TAM_OFF_CMD       8'h1C
`define TAM_OFF_EVENT     8'h20
`define TAM_CTRL_ALM_EN   0
`define TAM_CTRL_SELFCLR  1
`define TAM_CMD_CLEAR     0
`define TAM_CMD_CLR_ERR   1
`define TAM_CFG_EXP_LSB   16
`define TAM_CFG_EXP_W     4
`define TAM_CFG_DUR_W     12
`define TAM_SLIP_HRS_LSB  8
`define TAM_SLIP_HRS_W    5
`define TAM_EXP_MIN       4'h3
`define TAM_EXP_MAX       4'h9
`define TAM_EXP_SEC_MIN   4'h6
`define TAM_DUR_MAX       12'hE10
`define TAM_DUR_MIN_E7    12'h00A
`define TAM_DUR_MIN_E8    12'h064
`define TAM_DUR_MIN_E9    12'h3E8
`define TAM_DUR_MAX_E3    12'h015
`define TAM_DUR_MAX_E4    12'h0DA
`define TAM_DUR_MAX_E5    12'h864
`define TAM_RST_L1_EXP    4'h6
`define TAM_RST_L2_EXP    4'h5
`define TAM_RST_DUR       12'h00A
`define TAM_RST_SLIP_THR  8'h05
`define TAM_RST_SLIP_HRS  5'h02
`define TAM_SLIP_HRS_MAX  5'h18
`define TAM_ERR_SAT       16'hFDE8
`define TAM_SEC_PER_HOUR  12'hE10
`define TAM_TIME_DAY      17'h15180
`define TAM_CLK_MHZ       250
`define TAM_TICK_CYCLES   (`TAM_CLK_MHZ * 1000000)
`endif

// ### logic/tam_pkg.sv
// Types shared by the T1 alarm threshold monitor.
// Assumes the register header is included where offsets are needed.
package tam_pkg;
	typedef enum logic [1:0] {TAM_LVL0, TAM_LVL1, TAM_LVL2} tam_level_type;
	typedef struct packed {
		logic [3:0]  exponent;
		logic [11:0] duration;
	} tam_thr_type;
	typedef struct packed {
		logic contact_closed;
		logic fault_lamp;
		logic line_processing;
		logic yellow_alarm;
	} tam_ind_type;
endpackage

// ### logic/tam_monitor.sv
// T1 alarm threshold monitor: error-rate and frame-slip alarm evaluation with indications.
// Assumes error and slip pulses, the dip switch and the register port are on MCLK.
//
// Overview of operation
// - Software reads the stored time and writes hh:mm:ss or leaves it unchanged.
// - Software reads the stored date and writes mm/dd/yy or leaves it unchanged.
// - Three alarm levels; level zero drives no alarm output beyond a lamp and contact still latched awaiting manual clear.
// - Level one closes the contact, lights the lamp and posts a log event.
// - Level two adds line processing and yellow alarm toward customer equipment.
// - Line processing presents all ports on-hook or all off-hook per card switch.
// - Threshold exponents outside 3 to 9 are refused and flagged invalid.
// - Exponent n means 1500 errors per second divided by ten per step.
// - Duration limits depend on exponent; out-of-range durations are refused.
// - Durations are whole seconds from 1 to 3600.
// - Self-clearing clears contact and lamp at window end; otherwise manual clear.
// - Clearing reopens contact, darkens lamp, logs event; line processing ends for level two.
// - Without self-clearing, line supervision stops when the condition ends.
// - Alarm fires once window error count exceeds rate times window length.
// - Activation zeroes the counter; a further exceeding window extends the alarm.
// - Slips above a 1 to 255 threshold raise a level two alarm.
// - Slip period is 1 to 24 hours; slip counter zeroes at period end.
// - Defaults: exponent 6 and 10 s, exponent 5 and 10 s, 5 slips per 2 hours.
// - Each option reads back its current value and accepts a replacement.
// - The error counter saturates at 65000.
// - With alarms disabled no yellow alarm and no line processing; lamp continues.
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tam_regs.svh"
module tam_monitor
	import tam_pkg::*;
#(
	parameter int TICK_CYCLES = `TAM_TICK_CYCLES
)(
	input  wire logic        MCLK,
	input  wire logic        RST,
	input  wire logic        CE,
	input  wire logic        BIT_ERROR,
	input  wire logic        FRAME_SLIP,
	input  wire logic        HOOK_SWITCH,
	input  wire logic [7:0]  ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [31:0] RDATA,
	output logic             CONTACT_CLOSED,
	output logic             FAULT_LAMP,
	output logic             YELLOW_ALARM,
	output logic             LINE_PROCESSING,
	output logic             PORTS_OFF_HOOK,
	output logic             LOG_EVENT
);
////////////////////////////////////////////////////////////////////////////////
	// Allowed duration window for an exponent.
	function automatic logic cfg_ok(input logic [3:0] e, input logic [11:0] d);
		logic [11:0] lo;
		logic [11:0] hi;
		lo = 12'h001;
		hi = `TAM_DUR_MAX;
		if (e == 4'h3)
			hi = `TAM_DUR_MAX_E3;
		else if (e == 4'h4)
			hi = `TAM_DUR_MAX_E4;
		else if (e == 4'h5)
			hi = `TAM_DUR_MAX_E5;
		else if (e == 4'h7)
			lo = `TAM_DUR_MIN_E7;
		else if (e == 4'h8)
			lo = `TAM_DUR_MIN_E8;
		else if (e == 4'h9)
			lo = `TAM_DUR_MIN_E9;
		cfg_ok = (e >= `TAM_EXP_MIN) && (e <= `TAM_EXP_MAX) && (d >= lo) && (d <= hi);
	endfunction

	// Error limit for a window: 15 * 10^(6-e) * d / 10, kept in 32 bits.
	function automatic logic [31:0] err_limit(input logic [3:0] e, input logic [11:0] d);
		logic [31:0] base;
		base = 32'h0;
		if (e == 4'h3)
			base = 32'h3A98;
		else if (e == 4'h4)
			base = 32'h05DC;
		else if (e == 4'h5)
			base = 32'h0096;
		else if (e == 4'h6)
			base = 32'h000F;
		else if (e == 4'h7)
			base = 32'h0002;
		else
			base = 32'h0001;
		// Scaled in tenths of an error per second; below 1e-6 the window stretches the period.
		if (e <= `TAM_EXP_SEC_MIN)
			err_limit = (base * {20'h0, d}) / 32'hA;
		else if (e == 4'h7)
			err_limit = (32'hF * {20'h0, d}) / 32'h64;
		else if (e == 4'h8)
			err_limit = (32'hF * {20'h0, d}) / 32'h3E8;
		else
			err_limit = (32'hF * {20'h0, d}) / 32'h2710;
	endfunction
////////////////////////////////////////////////////////////////////////////////
	logic        err_s1, err_s2, slip_s1, slip_s2, hook_s1, hook_s2;
	logic [27:0] tick_cnt;
	logic        tick;
	tam_thr_type l1_cfg, l2_cfg;
	logic [7:0]  slip_thr;
	logic [4:0]  slip_hrs;
	logic        alarms_en, self_clr, param_invalid;
	logic [16:0] time_sec;
	logic [15:0] date_reg;
	logic [15:0] err_cnt, total_err;
	logic [11:0] win_l1, win_l2;
	logic [15:0] err2_cnt;
	logic [11:0] per_l1, per_l2;
	logic        win1_end, win2_end;
	logic [7:0]  slip_cnt;
	logic [11:0] hour_sec;
	logic [4:0]  hour_cnt;
	logic        cond1, cond2, cond_slip, act1, act2;
	tam_level_type level;
	logic        latched;
	logic        clear_cmd;
	tam_ind_type next_ind;
	logic        wr_cfg;

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			{err_s1, err_s2, slip_s1, slip_s2, hook_s1, hook_s2} <= 6'h00;
		end
		else if (CE)
		begin
			err_s1  <= BIT_ERROR;
			err_s2  <= err_s1;
			slip_s1 <= FRAME_SLIP;
			slip_s2 <= slip_s1;
			hook_s1 <= HOOK_SWITCH;
			hook_s2 <= hook_s1;
		end
	end

	// One-second tick from the system clock.
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			tick_cnt <= 28'h0;
			tick     <= 1'b0;
		end
		else if (CE)
		begin
			tick     <= (tick_cnt == 28'(TICK_CYCLES - 1));
			tick_cnt <= (tick_cnt == 28'(TICK_CYCLES - 1)) ? 28'h0 : tick_cnt + 28'h1;
		end
	end
////////////////////////////////////////////////////////////////////////////////
	// Configuration registers. Refused writes keep the old value and raise the flag.
	assign clear_cmd = CE && WR && (ADDR == `TAM_OFF_CMD) && WDATA[`TAM_CMD_CLEAR];
	assign wr_cfg    = CE && WR;
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			l1_cfg        <= '{`TAM_RST_L1_EXP, `TAM_RST_DUR};
			l2_cfg        <= '{`TAM_RST_L2_EXP, `TAM_RST_DUR};
			slip_thr      <= `TAM_RST_SLIP_THR;
			slip_hrs      <= `TAM_RST_SLIP_HRS;
			alarms_en     <= 1'b1;
			self_clr      <= 1'b1;
			param_invalid <= 1'b0;
			date_reg      <= 16'h0;
		end
		else if (wr_cfg)
		begin
			if (ADDR == `TAM_OFF_CTRL)
			begin
				alarms_en <= WDATA[`TAM_CTRL_ALM_EN];
				self_clr  <= WDATA[`TAM_CTRL_SELFCLR];
			end
			else if (ADDR == `TAM_OFF_L1CFG || ADDR == `TAM_OFF_L2CFG)
			begin
				if (cfg_ok(WDATA[19:16], WDATA[11:0]))
				begin
					if (ADDR == `TAM_OFF_L1CFG)
						l1_cfg <= '{WDATA[19:16], WDATA[11:0]};
					else
						l2_cfg <= '{WDATA[19:16], WDATA[11:0]};
				end
				else
					param_invalid <= 1'b1;
			end
			else if (ADDR == `TAM_OFF_SLIPCFG)
			begin
				if (WDATA[7:0] != 8'h00 && WDATA[12:8] != 5'h00 && WDATA[12:8] <= `TAM_SLIP_HRS_MAX)
				begin
					slip_thr <= WDATA[7:0];
					slip_hrs <= WDATA[12:8];
				end
				else
					param_invalid <= 1'b1;
			end
			else if (ADDR == `TAM_OFF_DATE)
				date_reg <= WDATA[15:0];
			else if (ADDR == `TAM_OFF_STATUS)
				param_invalid <= 1'b0;
		end
	end

	// Time of day in seconds since midnight.
	always_ff @(posedge MCLK)
	begin
		if (RST)
			time_sec <= 17'h0;
		else if (wr_cfg && ADDR == `TAM_OFF_TIME)
			time_sec <= WDATA[16:0];
		else if (CE && tick)
			time_sec <= (time_sec == `TAM_TIME_DAY - 17'h1) ? 17'h0 : time_sec + 17'h1;
	end
////////////////////////////////////////////////////////////////////////////////
	// Window error counters; each level counts over its own window, which restarts on activation.
	assign cond1     = {16'h0, err_cnt} > err_limit(l1_cfg.exponent, l1_cfg.duration);
	assign cond2     = {16'h0, err2_cnt} > err_limit(l2_cfg.exponent, l2_cfg.duration);
	assign win1_end  = tick && (per_l1 + 12'h1 >= l1_cfg.duration);
	assign win2_end  = tick && (per_l2 + 12'h1 >= l2_cfg.duration);

	// Fixed windows stand in for a sliding one, which would need a history of every second.
	always_ff @(posedge MCLK)
	begin
		if (RST || clear_cmd)
		begin
			err2_cnt <= 16'h0;
			per_l1   <= 12'h0;
			per_l2   <= 12'h0;
		end
		else if (CE)
		begin
			if (cond1 || win1_end)
				per_l1 <= 12'h0;
			else if (tick)
				per_l1 <= per_l1 + 12'h1;
			if (cond2 || win2_end)
				per_l2 <= 12'h0;
			else if (tick)
				per_l2 <= per_l2 + 12'h1;
			if (cond2 || win2_end)
				err2_cnt <= 16'h0;
			else if (err_s2 && err2_cnt != `TAM_ERR_SAT)
				err2_cnt <= err2_cnt + 16'h1;
		end
	end
	assign cond_slip = slip_cnt > slip_thr;

	always_ff @(posedge MCLK)
	begin
		if (RST || clear_cmd)
		begin
			err_cnt <= 16'h0;
			win_l1  <= 12'h0;
			win_l2  <= 12'h0;
			act1    <= 1'b0;
			act2    <= 1'b0;
		end
		else if (CE)
		begin
			if (cond1 || win1_end)
				err_cnt <= 16'h0;
			else if (err_s2 && err_cnt != `TAM_ERR_SAT)
				err_cnt <= err_cnt + 16'h1;
			if (cond2)
			begin
				act2   <= 1'b1;
				win_l2 <= l2_cfg.duration;
			end
			else if (tick && win_l2 != 12'h0)
				win_l2 <= win_l2 - 12'h1;
			else if (win_l2 == 12'h0)
				act2 <= 1'b0;
			if (cond1)
			begin
				act1   <= 1'b1;
				win_l1 <= l1_cfg.duration;
			end
			else if (tick && win_l1 != 12'h0)
				win_l1 <= win_l1 - 12'h1;
			else if (win_l1 == 12'h0)
				act1 <= 1'b0;
		end
	end

	// Frame slip window counted in hours.
	always_ff @(posedge MCLK)
	begin
		if (RST || clear_cmd)
		begin
			slip_cnt <= 8'h0;
			hour_sec <= 12'h0;
			hour_cnt <= 5'h0;
		end
		else if (CE)
		begin
			if (tick && hour_sec == `TAM_SEC_PER_HOUR - 12'h1)
			begin
				hour_sec <= 12'h0;
				if (hour_cnt + 5'h1 >= slip_hrs)
				begin
					hour_cnt <= 5'h0;
					slip_cnt <= 8'h0;
				end
				else
					hour_cnt <= hour_cnt + 5'h1;
			end
			else
			begin
				if (tick)
					hour_sec <= hour_sec + 12'h1;
				if (slip_s2 && slip_cnt != 8'hFF)
					slip_cnt <= slip_cnt + 8'h1;
			end
		end
	end

	// Total error counter, cleared only by its own command.
	always_ff @(posedge MCLK)
	begin
		if (RST || (CE && WR && ADDR == `TAM_OFF_CMD && WDATA[`TAM_CMD_CLR_ERR]))
			total_err <= 16'h0;
		else if (CE && err_s2 && total_err != `TAM_ERR_SAT)
			total_err <= total_err + 16'h1;
	end
////////////////////////////////////////////////////////////////////////////////
	// Alarm level and indications.
	always_comb
	begin
		next_ind = '0;
		if (act2 || cond_slip)
			level = TAM_LVL2;
		else if (act1)
			level = TAM_LVL1;
		else
			level = TAM_LVL0;
		next_ind.contact_closed  = (level != TAM_LVL0) || (!self_clr && latched);
		next_ind.fault_lamp      = next_ind.contact_closed;
		// Supervision follows the live condition even when lamp and contact stay latched.
		next_ind.line_processing = (level == TAM_LVL2) && alarms_en;
		next_ind.yellow_alarm    = next_ind.line_processing;
	end

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			latched         <= 1'b0;
			CONTACT_CLOSED  <= 1'b0;
			FAULT_LAMP      <= 1'b0;
			LINE_PROCESSING <= 1'b0;
			YELLOW_ALARM    <= 1'b0;
			PORTS_OFF_HOOK  <= 1'b0;
			LOG_EVENT       <= 1'b0;
		end
		else if (CE)
		begin
			// A live condition wins over a manual clear, so the alarm is declared again.
			if (level != TAM_LVL0)
				latched <= 1'b1;
			else if (clear_cmd)
				latched <= 1'b0;
			CONTACT_CLOSED  <= next_ind.contact_closed && !(clear_cmd && level == TAM_LVL0);
			FAULT_LAMP      <= next_ind.fault_lamp && !(clear_cmd && level == TAM_LVL0);
			LINE_PROCESSING <= next_ind.line_processing;
			YELLOW_ALARM    <= next_ind.yellow_alarm;
			PORTS_OFF_HOOK  <= next_ind.line_processing && hook_s2;
			LOG_EVENT       <= (next_ind.fault_lamp != FAULT_LAMP) && !(clear_cmd && level == TAM_LVL0)
				|| (clear_cmd && FAULT_LAMP && level == TAM_LVL0);
		end
	end

	// Register read port.
	always_ff @(posedge MCLK)
	begin
		if (RST)
			RDATA <= 32'h0;
		else if (CE && RD)
		begin
			if (ADDR == `TAM_OFF_CTRL)
				RDATA <= {30'h0, self_clr, alarms_en};
			else if (ADDR == `TAM_OFF_L1CFG)
				RDATA <= {12'h0, l1_cfg.exponent, 4'h0, l1_cfg.duration};
			else if (ADDR == `TAM_OFF_L2CFG)
				RDATA <= {12'h0, l2_cfg.exponent, 4'h0, l2_cfg.duration};
			else if (ADDR == `TAM_OFF_SLIPCFG)
				RDATA <= {19'h0, slip_hrs, slip_thr};
			else if (ADDR == `TAM_OFF_TIME)
				RDATA <= {15'h0, time_sec};
			else if (ADDR == `TAM_OFF_DATE)
				RDATA <= {16'h0, date_reg};
			else if (ADDR == `TAM_OFF_STATUS)
				RDATA <= {param_invalid, 5'h0, level, slip_cnt, err_cnt};
			else if (ADDR == `TAM_OFF_EVENT)
				RDATA <= {16'h0, total_err};
			else
				RDATA <= 32'h0;
		end
	end
////////////////////////////////////////////////////////////////////////////////
	property p_lvl0_quiet;
		@(posedge MCLK) disable iff (RST)
		(CE && !latched && level == TAM_LVL0) |=> !LINE_PROCESSING && !YELLOW_ALARM;
	endproperty
	a_lvl0_quiet: assert property (p_lvl0_quiet) else $error("Level zero drove an alarm.");

	property p_disabled_no_yellow;
		@(posedge MCLK) disable iff (RST)
		(CE && !alarms_en) |=> !YELLOW_ALARM;
	endproperty
	a_disabled_no_yellow: assert property (p_disabled_no_yellow) else $error("Yellow alarm while disabled.");

	property p_lvl2_lp;
		@(posedge MCLK) disable iff (RST)
		(CE && act2 && alarms_en) |=> LINE_PROCESSING && CONTACT_CLOSED;
	endproperty
	a_lvl2_lp: assert property (p_lvl2_lp) else $error("Level two missing line processing.");

	property p_err_sat;
		@(posedge MCLK) disable iff (RST)
		total_err <= `TAM_ERR_SAT;
	endproperty
	a_err_sat: assert property (p_err_sat) else $error("Error counter passed saturation.");

	property p_exp_range;
		@(posedge MCLK) disable iff (RST)
		l1_cfg.exponent >= `TAM_EXP_MIN && l1_cfg.exponent <= `TAM_EXP_MAX;
	endproperty
	a_exp_range: assert property (p_exp_range) else $error("Exponent out of range.");

	property p_zero_on_act;
		@(posedge MCLK) disable iff (RST)
		(CE && cond1 && !clear_cmd) |=> err_cnt == 16'h0;
	endproperty
	a_zero_on_act: assert property (p_zero_on_act) else $error("Counter not zeroed on activation.");

	property p_lamp_contact;
		@(posedge MCLK) disable iff (RST)
		FAULT_LAMP == CONTACT_CLOSED;
	endproperty
	a_lamp_contact: assert property (p_lamp_contact) else $error("Lamp and contact disagree.");

	property p_hook;
		@(posedge MCLK) disable iff (RST)
		PORTS_OFF_HOOK |-> LINE_PROCESSING;
	endproperty
	a_hook: assert property (p_hook) else $error("Off-hook outside line processing.");

	property p_slip_lvl2;
		@(posedge MCLK) disable iff (RST)
		(CE && cond_slip && alarms_en) |=> YELLOW_ALARM;
	endproperty
	a_slip_lvl2: assert property (p_slip_lvl2) else $error("Slip excess without level two.");
endmodule
`default_nettype wire

// ### test/tam_line_model.sv
// Line-side stand-in for the monitor: produces bit error and frame slip pulses.
// Assumes the monitor samples both pulses on MCLK and synchronises them itself.
`timescale 1ns/1ps
`default_nettype none
module tam_line_model (
	input  wire logic MCLK,
	output logic      BIT_ERROR,
	output logic      FRAME_SLIP
);
	initial
	begin
		BIT_ERROR = 1'b0;
		FRAME_SLIP = 1'b0;
	end
	//////////////////////////////////////////////////////////////////////////
	// Each pulse is one cycle wide; the gap lets a fast or slow line be modelled.
	task automatic pulse(input bit slip, input int n, input int gap);
		repeat (n)
		begin
			@(posedge MCLK);
			BIT_ERROR <= !slip;
			FRAME_SLIP <= slip;
			@(posedge MCLK);
			BIT_ERROR <= 1'b0;
			FRAME_SLIP <= 1'b0;
			repeat (gap) @(posedge MCLK);
		end
	endtask
endmodule
`default_nettype wire

// ### test/tam_monitor_tb.sv
// Self-checking bench for the T1 alarm threshold monitor.
// Assumes the register map header and a shortened one-second tick.
`timescale 1ns/1ps
`default_nettype none
`include "tam_regs.svh"
module tam_monitor_tb;
	localparam int TICK = 100;
	typedef struct {string name; logic [31:0] exp; logic [31:0] mask;} tam_note_type;
	logic        MCLK = 1'b0;
	logic        RST = 1'b1;
	logic        CE = 1'b1;
	logic        HOOK_SWITCH = 1'b0;
	logic        WR = 1'b0;
	logic        RD = 1'b0;
	logic [7:0]  ADDR = 8'h00;
	logic [31:0] WDATA = 32'h0;
	logic [31:0] RDATA;
	logic        BIT_ERROR;
	logic        FRAME_SLIP;
	logic        CONTACT_CLOSED;
	logic        FAULT_LAMP;
	logic        YELLOW_ALARM;
	logic        LINE_PROCESSING;
	logic        PORTS_OFF_HOOK;
	logic        LOG_EVENT;
	logic        rd_pend = 1'b0;
	tam_note_type notes[$];
	tam_note_type note;
	int          num_errors = 0;
	int          compares = 0;
	int          log_cnt = 0;
	logic [31:0] cfg_tab [15] = '{32'h0002000A, 32'h000A000A, 32'h00070009, 32'h0007000A, 32'h00030016,
		32'h00030015, 32'h00060000, 32'h00060E11, 32'h00060E10, 32'h000903E7, 32'h000903E8,
		32'h000400DB, 32'h000400DA, 32'h00050865, 32'h00050864};
	bit          ok_tab [15] = '{0, 0, 0, 1, 0, 1, 0, 0, 1, 0, 1, 0, 1, 0, 1};

	tam_monitor #(.TICK_CYCLES(TICK)) dut_u (.MCLK(MCLK), .RST(RST), .CE(CE), .BIT_ERROR(BIT_ERROR),
		.FRAME_SLIP(FRAME_SLIP), .HOOK_SWITCH(HOOK_SWITCH), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .CONTACT_CLOSED(CONTACT_CLOSED), .FAULT_LAMP(FAULT_LAMP), .YELLOW_ALARM(YELLOW_ALARM),
		.LINE_PROCESSING(LINE_PROCESSING), .PORTS_OFF_HOOK(PORTS_OFF_HOOK), .LOG_EVENT(LOG_EVENT));
	tam_line_model line_u (.MCLK(MCLK), .BIT_ERROR(BIT_ERROR), .FRAME_SLIP(FRAME_SLIP));

	initial
	begin
		forever #2 MCLK = ~MCLK;
	end
	//////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge MCLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge MCLK);
		WR <= 1'b0;
	endtask
	// The expected value is queued before the strobe so the monitor keeps read order.
	task automatic rd(input string name, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		notes.push_back('{name, e, m});
		@(posedge MCLK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge MCLK);
		RD <= 1'b0;
	endtask
	task automatic outs(input string name, input logic [4:0] e);
		@(negedge MCLK);
		check(name, {27'h0, CONTACT_CLOSED, FAULT_LAMP, YELLOW_ALARM, LINE_PROCESSING, PORTS_OFF_HOOK}, {27'h0, e});
	endtask
	// A wait that runs out is reported as a mismatch of the awaited level.
	task automatic wait_out(input string name, input bit yel, input logic v, input int lim);
		logic s;
		for (int i = 0; i <= lim; i++)
		begin
			@(negedge MCLK);
			s = yel ? YELLOW_ALARM : FAULT_LAMP;
			if (s === v)
				return;
		end
		check(name, {31'h0, s}, {31'h0, v});
	endtask
	//////////////////////////////////////////////////////////////////////////
	always @(posedge MCLK)
	begin
		if (rd_pend && notes.size() > 0)
		begin
			note = notes.pop_front();
			check(note.name, RDATA & note.mask, note.exp & note.mask);
		end
		rd_pend <= RD;
		if (LOG_EVENT === 1'b1)
			log_cnt++;
	end
	initial
	begin
		#200000;
		num_errors++;
		$display("[ERR] watchdog expected finish seen timeout");
		complete_run();
	end
	//////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [31:0] cur;
		logic [31:0] t;
		int lc;
		t = $urandom(32'h4DB4);
		repeat (12) @(posedge MCLK);
		RST <= 1'b0;
		outs("outputs after reset", 5'h00);
		rd("l1cfg default", `TAM_OFF_L1CFG, 32'h0006000A, 32'h000F0FFF);
		rd("l2cfg default", `TAM_OFF_L2CFG, 32'h0005000A, 32'h000F0FFF);
		rd("slipcfg default", `TAM_OFF_SLIPCFG, 32'h00000205, 32'h00001FFF);
		$display("test defaults done");
		cur = 32'h0006000A;
		for (int i = 0; i < 15; i++)
		begin
			wr(`TAM_OFF_L1CFG, cfg_tab[i]);
			if (ok_tab[i])
				cur = cfg_tab[i];
			rd("l1cfg readback", `TAM_OFF_L1CFG, cur, 32'h000F0FFF);
			rd("invalid flag", `TAM_OFF_STATUS, {~ok_tab[i], 31'h0}, 32'h80000000);
			wr(`TAM_OFF_STATUS, 32'h0);
		end
		$display("test limits done");
		// The time is even so that a tick landing between write and read only moves bit 0.
		t = ($urandom % 43200) * 2;
		wr(`TAM_OFF_TIME, t);
		// Clock enable low must freeze the seconds count, so the time may not move here.
		@(posedge MCLK);
		CE <= 1'b0;
		repeat (3 * TICK) @(posedge MCLK);
		CE <= 1'b1;
		rd("time", `TAM_OFF_TIME, t, 32'h0001FFFE);
		t = $urandom;
		wr(`TAM_OFF_DATE, t);
		rd("date", `TAM_OFF_DATE, t, 32'h0000FFFF);
		rd("unmapped", 8'h40, 32'h0, 32'hFFFFFFFF);
		$display("test time done");
		wr(`TAM_OFF_CTRL, 32'h3);
		wr(`TAM_OFF_L2CFG, 32'h00030001);
		wr(`TAM_OFF_L1CFG, 32'h00060002);
		lc = log_cnt;
		line_u.pulse(0, 3, 2);
		repeat (3 * TICK) @(posedge MCLK);
		outs("at limit no alarm", 5'h00);
		line_u.pulse(0, 8, 2);
		wait_out("lamp set", 0, 1'b1, 4 * TICK);
		outs("level one outputs", 5'b11000);
		rd("level one", `TAM_OFF_STATUS, 32'h01000000, 32'h03000000);
		wait_out("lamp self clear", 0, 1'b0, 8 * TICK);
		repeat (3) @(posedge MCLK);
		check("log events", log_cnt - lc, 32'h2);
		$display("test level one done");
		HOOK_SWITCH <= 1'($urandom);
		wr(`TAM_OFF_L2CFG, 32'h00050003);
		line_u.pulse(0, 120, 0);
		wait_out("yellow set", 1, 1'b1, 4 * TICK);
		outs("level two outputs", {4'b1111, HOOK_SWITCH});
		rd("level two", `TAM_OFF_STATUS, 32'h02000000, 32'h03000000);
		wait_out("lamp self clear", 0, 1'b0, 8 * TICK);
		outs("cleared outputs", 5'h00);
		$display("test level two done");
		wr(`TAM_OFF_CTRL, 32'h2);
		line_u.pulse(0, 120, 0);
		wait_out("lamp set", 0, 1'b1, 4 * TICK);
		outs("disabled outputs", 5'b11000);
		wait_out("lamp self clear", 0, 1'b0, 8 * TICK);
		$display("test disabled done");
		wr(`TAM_OFF_CTRL, 32'h1);
		line_u.pulse(0, 120, 0);
		wait_out("yellow set", 1, 1'b1, 4 * TICK);
		wait_out("yellow drop", 1, 1'b0, 8 * TICK);
		// Let the level one window run out too, so the clear meets no live level.
		repeat (3 * TICK) @(posedge MCLK);
		outs("latched lamp", 5'b11000);
		wr(`TAM_OFF_CMD, 32'h1);
		wait_out("manual clear", 0, 1'b0, 10);
		outs("cleared outputs", 5'h00);
		$display("test manual clear done");
		wr(`TAM_OFF_CTRL, 32'h3);
		wr(`TAM_OFF_SLIPCFG, 32'h00000101);
		line_u.pulse(1, 1, 2);
		repeat (3 * TICK) @(posedge MCLK);
		outs("slips at limit", 5'h00);
		line_u.pulse(1, 1, 2);
		wait_out("slip alarm", 1, 1'b1, 4 * TICK);
		rd("slip level", `TAM_OFF_STATUS, 32'h02020000, 32'h03FF0000);
		wr(`TAM_OFF_CMD, 32'h1);
		wait_out("slip clear", 0, 1'b0, 10);
		outs("cleared outputs", 5'h00);
		// Every error pulse sent so far: 11 in level one and 120 in each of three later tests.
		rd("total errors", `TAM_OFF_EVENT, 32'h00000173, 32'hFFFFFFFF);
		wr(`TAM_OFF_CMD, 32'h2);
		rd("total cleared", `TAM_OFF_EVENT, 32'h0, 32'hFFFFFFFF);
		$display("test slips done");
		complete_run();
	end
endmodule
`default_nettype wire
